// file: sic_pkg.sv
// Behaviour
// - class register low nibble holds a read-only four-bit device class code
// - read-only 16-bit part code, low byte at lower address, high byte next
// - variant register read-only: grade in upper nibble, hardware revision in lower
// - eight-bit test byte reads back the value last written, no other effect
// - read-only byte reports the serial interface standard revision
// - read-only 16-bit maker code, low byte at lower address, high byte next
// - streaming only: nonzero loop length returns address to start after that many bytes
// - loop length is eight bits, so at most 255 bytes per loop
// - loop length zero disables looping; address wraps at register space limits
// - transfer bits 7:6 select lanes, 00 single and 01 dual; host follows
// - keep bit clear: loop length cleared to zero at each transaction end
// - keep bit set: loop length unchanged across transaction ends
// - access-mode input picks streaming (auto step) or single-instruction access
// - direction input: clear steps address down by one, set steps up
package sic_pkg;
   localparam logic [6:0] OFF_CLASS = 7'h03;
   localparam logic [6:0] OFF_PART_LO = 7'h04;
   localparam logic [6:0] OFF_PART_HI = 7'h05;
   localparam logic [6:0] OFF_VARIANT = 7'h06;
   localparam logic [6:0] OFF_TEST = 7'h0a;
   localparam logic [6:0] OFF_VERSION = 7'h0b;
   localparam logic [6:0] OFF_MAKER_LO = 7'h0c;
   localparam logic [6:0] OFF_MAKER_HI = 7'h0d;
   localparam logic [6:0] OFF_LOOP = 7'h0e;
   localparam logic [6:0] OFF_XFER = 7'h0f;
   localparam logic [6:0] ADDR_TOP = 7'h7f;
   localparam int INSTR_RD_BIT = 7;
   localparam int XFER_LANE_HI = 7;
   localparam int XFER_LANE_LO = 6;
   localparam int XFER_KEEP_BIT = 2;
   localparam logic [1:0] LANE_SINGLE = 2'h0;
   localparam logic [1:0] LANE_DUAL = 2'h1;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [7:0] LOOP_RST = 8'h00;
   localparam logic [1:0] LANE_RST = 2'h0;
   localparam logic KEEP_RST = 1'h0;
   // identity defaults: arbitrary neutral values
   localparam logic [3:0] CLASS_DEF = 4'h1;
   localparam logic [15:0] PART_DEF = 16'h1234;
   localparam logic [3:0] GRADE_DEF = 4'h0;
   localparam logic [3:0] REV_DEF = 4'h1;
   localparam logic [7:0] VERSION_DEF = 8'h10;
   localparam logic [15:0] MAKER_DEF = 16'h00a5;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_INSTR = 3'h2,
      ST_DATA = 3'h4
   } sic_state_t;
endpackage

// file: sic_link_if.sv
`timescale 1ns/1ps
interface sic_link_if;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic cs_end;
   logic [7:0] tx_byte;
   logic drive;
   logic dual;
   logic [6:0] cur_addr;
   logic [6:0] start_addr;
   logic [6:0] next_addr;
   logic [7:0] loop_len;
   logic [7:0] step_cnt;
   logic ascend;
   logic looped;
   modport shf (output rx_byte, rx_valid, cs_end, input tx_byte, drive, dual);
   modport stp (input cur_addr, start_addr, loop_len, step_cnt, ascend, output next_addr, looped);
   modport ctl (input rx_byte, rx_valid, cs_end, next_addr, looped,
                output tx_byte, drive, dual, cur_addr, start_addr, loop_len, step_cnt, ascend);
endinterface

// file: sic_shifter.sv
`timescale 1ns/1ps
module sic_shifter
   import sic_pkg::*;
(
   input logic clk,
   input logic resetn,
   input logic cs_n,
   input logic sclk,
   input logic [1:0] sdio_i,
   output logic [1:0] sdio_o,
   output logic [1:0] sdio_oe,
   sic_link_if.shf lk
);
   logic sclk_q_r;
   logic cs_q_r;
   logic [2:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] out_r;
   logic [7:0] rx_r;
   logic rx_v_r;
   logic [1:0] pin_r;
   logic [1:0] oe_r;

   // sclk is oversampled, so it must stay high and low for two clk periods each
   wire rise = ~cs_n & sclk & ~sclk_q_r;
   wire fall = ~cs_n & ~sclk & sclk_q_r;
   wire [2:0] step = lk.dual ? 3'h2 : 3'h1;
   wire [2:0] cnt_nxt = 3'(cnt_r + step);
   wire byte_done = rise & (cnt_nxt == 3'h0);
   wire [7:0] sh_nxt = lk.dual ? {sh_r[5:0], sdio_i} : {sh_r[6:0], sdio_i[0]};
   wire [7:0] out_shift = lk.dual ? {out_r[5:0], 2'h0} : {out_r[6:0], 1'h0};
   wire [7:0] out_nxt = (cnt_r == 3'h0) ? lk.tx_byte : out_shift;
   wire [1:0] pin_nxt = lk.dual ? out_nxt[7:6] : {out_nxt[7], 1'h0};
   wire [1:0] oe_lanes = lk.dual ? 2'h3 : 2'h2;
   wire [1:0] oe_nxt = (lk.drive & ~cs_n) ? oe_lanes : 2'h0;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sclk_q_r <= 1'h0;
         cs_q_r <= 1'h1;
         cnt_r <= 3'h0;
         sh_r <= 8'h00;
         out_r <= 8'h00;
         rx_r <= 8'h00;
         rx_v_r <= 1'h0;
         pin_r <= 2'h0;
         oe_r <= 2'h0;
      end
      else
      begin
         sclk_q_r <= sclk;
         cs_q_r <= cs_n;
         rx_v_r <= byte_done;
         oe_r <= oe_nxt;
         cnt_r <= cs_n ? 3'h0 : (rise ? cnt_nxt : cnt_r);
         sh_r <= rise ? sh_nxt : sh_r;
         rx_r <= byte_done ? sh_nxt : rx_r;
         out_r <= fall ? out_nxt : out_r;
         pin_r <= fall ? pin_nxt : pin_r;
      end
   end

   assign lk.rx_byte = rx_r;
   assign lk.rx_valid = rx_v_r;
   assign lk.cs_end = cs_n & ~cs_q_r;
   assign sdio_o = pin_r;
   assign sdio_oe = oe_r;
endmodule // sic_shifter

// file: sic_addr_step.sv
`timescale 1ns/1ps
module sic_addr_step
   import sic_pkg::*;
(
   sic_link_if.stp lk
);
   wire [6:0] addr_up = 7'(lk.cur_addr + 7'h01);
   wire [6:0] addr_down = 7'(lk.cur_addr - 7'h01);
   // seven-bit arithmetic wraps at 0x00 and the top of the space
   wire [6:0] seq_addr = lk.ascend ? addr_up : addr_down;
   wire [7:0] cnt_inc = 8'(lk.step_cnt + 8'h01);

   assign lk.looped = (lk.loop_len != 8'h00) && (cnt_inc == lk.loop_len);
   assign lk.next_addr = lk.looped ? lk.start_addr : seq_addr;
endmodule // sic_addr_step

// file: sic_regbank.sv
`timescale 1ns/1ps
module sic_regbank
   import sic_pkg::*;
#(
   parameter logic [3:0] CLASS_CODE = CLASS_DEF,
   parameter logic [15:0] PART_CODE = PART_DEF,
   parameter logic [3:0] GRADE_CODE = GRADE_DEF,
   parameter logic [3:0] REV_CODE = REV_DEF,
   parameter logic [7:0] VERSION_CODE = VERSION_DEF,
   parameter logic [15:0] MAKER_CODE = MAKER_DEF
)
(
   input logic clk,
   input logic resetn,
   input logic cs_n,
   input logic sclk,
   input logic [1:0] sdio_i,
   input logic addr_ascend,
   input logic single_instr,
   output logic [1:0] sdio_o,
   output logic [1:0] sdio_oe,
   output logic lane_dual
);
   sic_link_if lk ();

   sic_shifter u_shf (
      .clk(clk),
      .resetn(resetn),
      .cs_n(cs_n),
      .sclk(sclk),
      .sdio_i(sdio_i),
      .sdio_o(sdio_o),
      .sdio_oe(sdio_oe),
      .lk(lk.shf)
   );

   sic_addr_step u_stp (
      .lk(lk.stp)
   );

   sic_state_t state_r;
   sic_state_t state_nxt;
   logic rd_r;
   logic [6:0] addr_r;
   logic [6:0] start_r;
   logic [7:0] cnt_r;
   logic [7:0] tx_r;
   logic drive_r;
   logic dual_r;
   logic [7:0] test_r;
   logic [7:0] loop_r;
   logic [1:0] lane_r;
   logic keep_r;

   function automatic logic [7:0] rd_mux(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         OFF_CLASS: v = {4'h0, CLASS_CODE};
         OFF_PART_LO: v = PART_CODE[7:0];
         OFF_PART_HI: v = PART_CODE[15:8];
         OFF_VARIANT: v = {GRADE_CODE, REV_CODE};
         OFF_TEST: v = test_r;
         OFF_VERSION: v = VERSION_CODE;
         OFF_MAKER_LO: v = MAKER_CODE[7:0];
         OFF_MAKER_HI: v = MAKER_CODE[15:8];
         OFF_LOOP: v = loop_r;
         OFF_XFER: v = {lane_r, 3'h0, keep_r, 2'h0};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // byte classification
   wire stream = ~single_instr;
   wire instr_take = lk.rx_valid & (state_r != ST_DATA);
   wire data_take = lk.rx_valid & (state_r == ST_DATA);
   wire step_take = data_take & stream;
   wire wr_take = data_take & ~rd_r;
   wire wr_test = wr_take & (addr_r == OFF_TEST);
   wire wr_loop = wr_take & (addr_r == OFF_LOOP);
   wire wr_xfer = wr_take & (addr_r == OFF_XFER);
   wire len_clear = lk.cs_end & ~keep_r;

   // read data for the byte the host will clock out next
   wire [7:0] rdata_instr = rd_mux(lk.rx_byte[6:0]);
   wire [7:0] rdata_next = rd_mux(lk.next_addr);

   // a loop of length one rereads the old value if that byte was just written
   wire [6:0] addr_nxt = instr_take ? lk.rx_byte[6:0] :
                         (step_take ? lk.next_addr : addr_r);
   wire [7:0] cnt_inc = 8'(cnt_r + 8'h01);
   wire [7:0] cnt_step = lk.looped ? 8'h00 : cnt_inc;
   wire [7:0] cnt_nxt = instr_take ? 8'h00 : (step_take ? cnt_step : cnt_r);
   wire [7:0] tx_nxt = instr_take ? rdata_instr : (step_take ? rdata_next : tx_r);
   wire drive_keep = (data_take & single_instr) ? 1'h0 : drive_r;
   wire drive_set = instr_take ? lk.rx_byte[INSTR_RD_BIT] : drive_keep;
   wire drive_nxt = lk.cs_end ? 1'h0 : drive_set;
   wire [7:0] loop_nxt = wr_loop ? lk.rx_byte : (len_clear ? 8'h00 : loop_r);
   wire [1:0] lane_nxt = wr_xfer ? lk.rx_byte[XFER_LANE_HI:XFER_LANE_LO] : lane_r;
   wire keep_nxt = wr_xfer ? lk.rx_byte[XFER_KEEP_BIT] : keep_r;
   // lane mode only changes between transactions so a frame never switches mid-byte
   wire dual_nxt = (state_r == ST_IDLE) ? (lane_r == LANE_DUAL) : dual_r;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE,
         ST_INSTR:
         begin
            if (lk.rx_valid)
               state_nxt = ST_DATA;
         end
         ST_DATA:
         begin
            if (lk.rx_valid & single_instr)
               state_nxt = ST_INSTR;
         end
      endcase
      if (lk.cs_end)
         state_nxt = ST_IDLE;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_r <= ST_IDLE;
         rd_r <= 1'h0;
         addr_r <= 7'h00;
         start_r <= 7'h00;
         cnt_r <= 8'h00;
         tx_r <= 8'h00;
         drive_r <= 1'h0;
         dual_r <= 1'h0;
      end
      else
      begin
         state_r <= state_nxt;
         rd_r <= instr_take ? lk.rx_byte[INSTR_RD_BIT] : rd_r;
         addr_r <= addr_nxt;
         start_r <= instr_take ? lk.rx_byte[6:0] : start_r;
         cnt_r <= cnt_nxt;
         tx_r <= tx_nxt;
         drive_r <= drive_nxt;
         dual_r <= dual_nxt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         test_r <= TEST_RST;
         loop_r <= LOOP_RST;
         lane_r <= LANE_RST;
         keep_r <= KEEP_RST;
      end
      else
      begin
         test_r <= wr_test ? lk.rx_byte : test_r;
         loop_r <= loop_nxt;
         lane_r <= lane_nxt;
         keep_r <= keep_nxt;
      end
   end

   assign lk.tx_byte = tx_r;
   assign lk.drive = drive_r;
   assign lk.dual = dual_r;
   assign lk.cur_addr = addr_r;
   assign lk.start_addr = start_r;
   assign lk.loop_len = loop_r;
   assign lk.step_cnt = cnt_r;
   assign lk.ascend = addr_ascend;
   assign lane_dual = dual_r;

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_class_read: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_CLASS |=> tx_r == {4'h0, CLASS_CODE})
      else $error("class register read wrong");

   a_part_split: assert property (
      step_take && !lk.cs_end && lk.next_addr == OFF_PART_HI
      |=> tx_r == PART_CODE[15:8])
      else $error("part code high byte misplaced");

   a_part_low: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_PART_LO |=> tx_r == PART_CODE[7:0])
      else $error("part code low byte misplaced");

   a_variant_read: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_VARIANT
      |=> tx_r[7:4] == GRADE_CODE && tx_r[3:0] == REV_CODE)
      else $error("variant nibbles wrong");

   a_test_echo: assert property (
      wr_test |=> test_r == $past(lk.rx_byte))
      else $error("test byte did not take the write");

   a_test_hold: assert property (
      !wr_test |=> test_r == $past(test_r))
      else $error("test byte changed without a write");

   a_version_read: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_VERSION |=> tx_r == VERSION_CODE)
      else $error("interface version wrong");

   a_maker_read: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_MAKER_HI |=> tx_r == MAKER_CODE[15:8])
      else $error("maker code high byte wrong");

   a_loop_return: assert property (
      step_take && !lk.cs_end && loop_r != 8'h00 && cnt_inc == loop_r
      |=> addr_r == $past(start_r) && cnt_r == 8'h00)
      else $error("stream did not return to start address");

   a_loop_full: assert property (
      step_take && !lk.cs_end && loop_r == 8'hff && cnt_r == 8'hfe
      |=> cnt_r == 8'h00 && addr_r == $past(start_r))
      else $error("255 byte loop did not close");

   a_wrap_top: assert property (
      step_take && !lk.cs_end && loop_r == 8'h00 && addr_ascend && addr_r == ADDR_TOP
      |=> addr_r == 7'h00)
      else $error("ascending stream did not wrap to zero");

   a_lane_latch: assert property (
      state_r == ST_IDLE |=> lane_dual == ($past(lane_r) == LANE_DUAL))
      else $error("lane mode not taken between transactions");

   a_dual_drive: assert property (
      drive_r && !cs_n && dual_r |=> sdio_oe == 2'h3)
      else $error("dual read does not drive both lanes");

   a_len_clear: assert property (
      lk.cs_end && !keep_r && !wr_loop |=> loop_r == 8'h00)
      else $error("loop length survived transaction end");

   a_len_keep: assert property (
      lk.cs_end && keep_r && !wr_loop |=> loop_r == $past(loop_r))
      else $error("loop length lost with keep set");

   a_xfer_reserved: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_XFER
      |=> tx_r[5:3] == 3'h0 && tx_r[1:0] == 2'h0)
      else $error("reserved transfer bits not zero");

   a_single_instr: assert property (
      data_take && single_instr && !lk.cs_end
      |=> state_r == ST_INSTR && addr_r == $past(addr_r) && !drive_r)
      else $error("single instruction access did not end");

   a_step_down: assert property (
      step_take && !lk.cs_end && !addr_ascend && !lk.looped
      |=> addr_r == 7'($past(addr_r) - 7'h01))
      else $error("descending step wrong");

   a_step_up: assert property (
      step_take && !lk.cs_end && addr_ascend && !lk.looped
      |=> addr_r == 7'($past(addr_r) + 7'h01))
      else $error("ascending step wrong");

   a_test_read: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_TEST |=> tx_r == $past(test_r))
      else $error("test byte read returned wrong value");

   a_maker_low: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_MAKER_LO |=> tx_r == MAKER_CODE[7:0])
      else $error("maker code low byte wrong");

   a_maker_split: assert property (
      step_take && !lk.cs_end && lk.next_addr == OFF_MAKER_HI
      |=> tx_r == MAKER_CODE[15:8])
      else $error("maker code high byte misplaced");

   a_part_high: assert property (
      instr_take && lk.rx_byte[6:0] == OFF_PART_HI |=> tx_r == PART_CODE[15:8])
      else $error("part code high byte wrong");

   a_class_step: assert property (
      step_take && !lk.cs_end && lk.next_addr == OFF_CLASS
      |=> tx_r == {4'h0, CLASS_CODE})
      else $error("class register stream read wrong");

   a_variant_step: assert property (
      step_take && !lk.cs_end && lk.next_addr == OFF_VARIANT
      |=> tx_r == {GRADE_CODE, REV_CODE})
      else $error("variant stream read wrong");

   a_version_step: assert property (
      step_take && !lk.cs_end && lk.next_addr == OFF_VERSION
      |=> tx_r == VERSION_CODE)
      else $error("interface version stream read wrong");

   a_wrap_bottom: assert property (
      step_take && !lk.cs_end && loop_r == 8'h00 && !addr_ascend && addr_r == 7'h00
      |=> addr_r == ADDR_TOP)
      else $error("descending stream did not wrap to top");

   a_unmapped_zero: assert property (
      step_take && !lk.cs_end && lk.next_addr > OFF_XFER |=> tx_r == 8'h00)
      else $error("unmapped address did not read zero");

   a_loop_write: assert property (
      wr_loop |=> loop_r == $past(lk.rx_byte))
      else $error("loop length write lost");

   a_loop_hold: assert property (
      !lk.cs_end && !wr_loop |=> loop_r == $past(loop_r))
      else $error("loop length changed without cause");

   a_lane_write: assert property (
      wr_xfer |=> lane_r == $past(lk.rx_byte[XFER_LANE_HI:XFER_LANE_LO]))
      else $error("lane field write lost");

   a_keep_write: assert property (
      wr_xfer |=> keep_r == $past(lk.rx_byte[XFER_KEEP_BIT]))
      else $error("keep bit write lost");

   a_single_drive: assert property (
      drive_r && !cs_n && !dual_r |=> sdio_oe == 2'h2)
      else $error("single read does not drive one lane");

   a_idle_quiet: assert property (
      cs_n |=> sdio_oe == 2'h0)
      else $error("lanes driven outside a frame");

   a_instr_start: assert property (
      instr_take |=> addr_r == $past(lk.rx_byte[6:0]) && start_r == $past(lk.rx_byte[6:0])
      && cnt_r == 8'h00)
      else $error("instruction did not set start address");

   a_stream_count: assert property (
      step_take && !lk.cs_end && !lk.looped |=> cnt_r == 8'($past(cnt_r) + 8'h01))
      else $error("stream byte count did not advance");

   a_single_hold: assert property (
      single_instr && !instr_take |=> addr_r == $past(addr_r))
      else $error("address moved in single instruction access");

   a_frame_release: assert property (
      lk.cs_end |=> !drive_r && state_r == ST_IDLE)
      else $error("frame end did not release the bus");
endmodule // sic_regbank

// file: sic_spi_host.sv
`timescale 1ns/1ps
module sic_spi_host
(
   input wire logic clk,
   input wire logic [1:0] sdio_o,
   input wire logic [1:0] sdio_oe,
   output logic cs_n,
   output logic sclk,
   output wire logic [1:0] sdio_i
);
   logic [1:0] h_o;
   logic [1:0] h_oe;
   logic [1:0] junk;
   logic dual_mode;
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      h_o = 2'h0;
      h_oe = 2'h0;
      junk = 2'h1;
      dual_mode = 1'b0;
   end
   // released lanes toggle so a stale level can never pass for read data
   always @(posedge clk) junk <= ~junk;
   assign sdio_i[0] = sdio_oe[0] ? sdio_o[0] : (h_oe[0] ? h_o[0] : junk[0]);
   assign sdio_i[1] = sdio_oe[1] ? sdio_o[1] : (h_oe[1] ? h_o[1] : junk[1]);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic frame_begin();
      tick(1);
      cs_n = 1'b0;
      h_oe = dual_mode ? 2'h3 : 2'h1;
   endtask
   task automatic frame_end();
      tick(1);
      cs_n = 1'b1;
      h_oe = 2'h0;
      tick(4);
   endtask
   // one byte, msb first; sclk high and low three clocks each
   task automatic xbyte(input logic [7:0] w, input logic drv, output logic [7:0] r,
                        output logic [1:0] oe);
      int i;
      logic [7:0] sh;
      sh = w;
      r = 8'h00;
      oe = 2'h0;
      for (i = 0; i < (dual_mode ? 4 : 8); i++)
      begin
         h_o = dual_mode ? sh[7:6] : {1'b0, sh[7]};
         h_oe = dual_mode ? (drv ? 2'h3 : 2'h0) : 2'h1;
         tick(3);
         r = dual_mode ? {r[5:0], sdio_i} : {r[6:0], sdio_i[1]};
         oe = sdio_oe;
         sclk = 1'b1;
         tick(3);
         sclk = 1'b0;
         sh = dual_mode ? sh << 2 : sh << 1;
      end
   endtask
endmodule // sic_spi_host

// file: tb_sic_regbank.sv
`timescale 1ns/1ps
module tb_sic_regbank;
   import sic_pkg::*;
   logic clk;
   logic resetn;
   logic addr_ascend;
   logic single_instr;
   wire logic cs_n;
   wire logic sclk;
   wire logic [1:0] sdio_i;
   wire logic [1:0] sdio_o;
   wire logic [1:0] sdio_oe;
   wire logic lane_dual;
   logic [7:0] test_v;
   logic [7:0] loop_v;
   logic [7:0] xfer_v;
   logic [7:0] rb;
   logic [1:0] ob;
   int fails = 0;
   int samples_checked = 0;
   sic_regbank dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .sdio_i(sdio_i),
      .addr_ascend(addr_ascend), .single_instr(single_instr), .sdio_o(sdio_o),
      .sdio_oe(sdio_oe), .lane_dual(lane_dual));
   sic_spi_host host (.clk(clk), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .cs_n(cs_n),
      .sclk(sclk), .sdio_i(sdio_i));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic test_done();
      if (fails == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   function automatic logic [7:0] exp_rd(input logic [6:0] a);
      case (a)
         OFF_CLASS: exp_rd = {4'h0, CLASS_DEF};
         OFF_PART_LO: exp_rd = PART_DEF[7:0];
         OFF_PART_HI: exp_rd = PART_DEF[15:8];
         OFF_VARIANT: exp_rd = {GRADE_DEF, REV_DEF};
         OFF_TEST: exp_rd = test_v;
         OFF_VERSION: exp_rd = VERSION_DEF;
         OFF_MAKER_LO: exp_rd = MAKER_DEF[7:0];
         OFF_MAKER_HI: exp_rd = MAKER_DEF[15:8];
         OFF_LOOP: exp_rd = loop_v;
         OFF_XFER: exp_rd = xfer_v;
         default: exp_rd = 8'h00;
      endcase
   endfunction
   // frame end clears the loop count unless kept; lane mode applies from the next frame
   task automatic end_frame();
      host.frame_end();
      if (xfer_v[2] == 1'b0)
         loop_v = 8'h00;
      host.dual_mode = (xfer_v[7:6] == LANE_DUAL);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.frame_begin();
      host.xbyte({1'b0, a}, 1'b1, rb, ob);
      host.xbyte(d, 1'b1, rb, ob);
      if (a == OFF_TEST)
         test_v = d;
      if (a == OFF_LOOP)
         loop_v = d;
      if (a == OFF_XFER)
         xfer_v = d & 8'hc4;
      end_frame();
   endtask
   task automatic stream_rd(input logic [6:0] a, input int n);
      logic [6:0] ea;
      int k;
      int lp;
      ea = a;
      lp = loop_v;
      host.frame_begin();
      host.xbyte({1'b1, a}, 1'b1, rb, ob);
      for (k = 0; k < n; k++)
      begin
         host.xbyte(8'h00, 1'b0, rb, ob);
         check($sformatf("reg %h", ea), exp_rd(ea), rb);
         check("read enable", {7'h00, host.dual_mode} | 8'h02, {6'h00, ob});
         if (lp != 0 && (k + 1) % lp == 0)
            ea = a;
         else
            ea = addr_ascend ? ea + 7'h01 : ea - 7'h01;
      end
      end_frame();
   endtask
   initial
   begin
      repeat (40000) @(posedge clk);
      fails++;
      test_done();
   end
   initial
   begin
      resetn = 1'b0;
      addr_ascend = 1'b1;
      single_instr = 1'b0;
      test_v = TEST_RST;
      loop_v = LOOP_RST;
      xfer_v = 8'h00;
      repeat (2) @(posedge clk);
      #5 resetn = 1'b1;
      stream_rd(OFF_CLASS, 13);
      wr(OFF_TEST, 8'h5a);
      wr(OFF_PART_LO, 8'hff);
      wr(OFF_VERSION, 8'h00);
      stream_rd(OFF_PART_LO, 7);
      wr(OFF_XFER, 8'hbf);
      check("lane dual", 8'h00, {7'h00, lane_dual});
      wr(OFF_LOOP, 8'hff);
      stream_rd(OFF_LOOP, 256);
      wr(OFF_LOOP, 8'h03);
      stream_rd(OFF_TEST, 7);
      wr(OFF_XFER, 8'h44);
      check("lane dual", 8'h01, {7'h00, lane_dual});
      stream_rd(OFF_TEST, 5);
      addr_ascend = 1'b0;
      stream_rd(OFF_MAKER_HI, 4);
      wr(OFF_XFER, 8'h00);
      check("lane dual", 8'h00, {7'h00, lane_dual});
      stream_rd(OFF_LOOP, 3);
      stream_rd(7'h01, 3);
      addr_ascend = 1'b1;
      stream_rd(ADDR_TOP, 2);
      single_instr = 1'b1;
      host.frame_begin();
      host.xbyte({1'b1, OFF_TEST}, 1'b1, rb, ob);
      host.xbyte(8'h00, 1'b0, rb, ob);
      check("single test", test_v, rb);
      host.xbyte({1'b1, OFF_MAKER_LO}, 1'b1, rb, ob);
      host.xbyte(8'h00, 1'b0, rb, ob);
      check("single maker", MAKER_DEF[7:0], rb);
      end_frame();
      test_done();
   end
endmodule // tb_sic_regbank
